// ==== design/wdt_defines.svh ====
// Offsets, field positions, reset values and timing counts of the watchdog.
// Assumes it is included by bare name from every file that needs a figure.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define WDT_CTRL_IDX       8'h21
`define WDT_CAUSE_IDX      8'h22
`define WDT_CTRL_ADDR      12'h084
`define WDT_CAUSE_ADDR     12'h088

// Field positions in the control register.
`define WDT_B_IRQ_FLAG     7
`define WDT_B_IRQ_EN       6
`define WDT_B_SEL_MSB      5
`define WDT_B_CHG_EN       4
`define WDT_B_WD_EN        3
// Field position of the cause flag in the reset cause register.
`define WDT_B_CAUSE        3

// Reset values.
`define WDT_RST_SEL        4'h0
`define WDT_RST_CE_CNT     3'h0

// Timing: oscillator rate, system rate, change-enable window.
`define WDT_OSC_KHZ        128
`define WDT_CLK_KHZ        125000
`define WDT_OSC_DIV        (`WDT_CLK_KHZ / `WDT_OSC_KHZ)
`define WDT_CE_CYCLES      4
`define WDT_BASE_TICKS     2048
`define WDT_SEL_MAX        4'h9

`endif

// ==== design/wdt_period_cnt.sv ====
// Watchdog counter in oscillator ticks with selectable time-out period.
// Assumes tick_i is a one-cycle enable and clear_i wins over counting.
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_period_cnt (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       tick_i,
    input  wire logic       clear_i,
    input  wire logic [3:0] sel_i,
    output logic            expire_o
);
    wdt_pkg::wdt_cnt_s r_reg;
    wdt_pkg::wdt_cnt_s r_next;
    logic [3:0]        sel_eff;
    logic [19:0]       term;

    // Reserved codes behave as the longest period.
    assign sel_eff = (sel_i > `WDT_SEL_MAX) ? `WDT_SEL_MAX : sel_i;
    assign term = 20'((21'(`WDT_BASE_TICKS) << sel_eff) - 21'h00_0001);

    always_comb
    begin
        r_next = r_reg;
        r_next.expire = 1'b0;
        if (clear_i)
        begin
            r_next.cnt = 20'h0_0000;
        end
        else if (tick_i)
        begin
            if (r_reg.cnt >= term)
            begin
                r_next.cnt    = 20'h0_0000;
                r_next.expire = 1'b1;
            end
            else
            begin
                r_next.cnt = r_reg.cnt + 20'h0_0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign expire_o = r_reg.expire;

    a_clear_zero: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        clear_i |=> r_reg.cnt == 20'h0_0000 && !expire_o)
        else $error("counter not zero after clear");

    a_period_end: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        tick_i && !clear_i && r_reg.cnt == term
        |=> expire_o && r_reg.cnt == 20'h0_0000)
        else $error("time-out not at selected period");

endmodule : wdt_period_cnt

// ==== design/wdt_pkg.sv ====
// Types shared by the watchdog modules.
// Assumes the figures themselves come from wdt_defines.svh.
package wdt_pkg;

    typedef enum logic [0:0] {
        WDT_CE_CLOSED = 1'b0,
        WDT_CE_OPEN   = 1'b1
    } wdt_ce_e;

    typedef struct packed {
        logic        irq_flag;
        logic        irq_en;
        logic [3:0]  sel;
        logic        wd_en;
        wdt_ce_e     ce_state;
        logic [2:0]  ce_cnt;
        logic        cause;
        logic        rst_pulse;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wdt_state_s;

    typedef struct packed {
        logic [19:0] cnt;
        logic        expire;
    } wdt_cnt_s;

    typedef struct packed {
        logic [15:0] div;
        logic        tick;
    } wdt_tick_s;

endpackage : wdt_pkg

// ==== design/wdt_tick_gen.sv ====
// Divider that stands in for the watchdog oscillator as an enable pulse.
// Assumes one system clock; DIV system cycles make one oscillator cycle.
`timescale 1ns/1ns
module wdt_tick_gen #(
    parameter int DIV = 976
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    output logic      tick_o
);
    wdt_pkg::wdt_tick_s r_reg;
    wdt_pkg::wdt_tick_s r_next;

    // The oscillator is an enable in the system domain, so restart,
    // enable and period changes need no crossing at all.
    always_comb
    begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (r_reg.div >= 16'(DIV - 1))
        begin
            r_next.div  = 16'h0000;
            r_next.tick = 1'b1;
        end
        else
        begin
            r_next.div = r_reg.div + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign tick_o = r_reg.tick;

endmodule : wdt_tick_gen

// ==== design/wdt_watchdog.sv ====
// Watchdog timer with APB control registers, reset and interrupt actions.
// Assumes one 125 MHz clock; the fuse, the restart, the vector-taken strobe
// and the global interrupt enable are synchronous to it.
`timescale 1ns/1ns
`include "wdt_defines.svh"

// Contract
// - Counter advances on the 128 kHz oscillator
// - Restart instruction clears the counter
// - Disable and any chip reset clear counter
// - Ten periods; expiry with reset action resets
// - Fuse picks safety level one or two
// - Period select split: bit 5, bits 2:0
// - Time-out flag set; cleared by vector/write-one
// - Interrupt needs global and watchdog enables
// - Enable pair selects stop, interrupt or reset
// - Reset enabled: time-out clears interrupt enable
// - Change-enable self-clears after four cycles
// - Enable clear needs change-enable; period change needs it in level two only
// - Level two keeps watchdog always enabled
// - Level one: cause flag forces enable on
// - Codes 0-9 give 2048 to 1048576 ticks
// - Watchdog reset pulse lasts one cycle
// - Cause flag set on watchdog reset, cleared by zero
// - Level two: enable value in second write ignored
module wdt_watchdog #(
    parameter int OSC_DIV = `WDT_OSC_DIV
) (
    // Clock and power-on reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Core side
    input  wire logic        CHIP_RST_I,
    input  wire logic        RESTART_I,
    input  wire logic        IRQ_TAKEN_I,
    input  wire logic        GLOBAL_IRQ_EN_I,
    input  wire logic        SAFETY_LEVEL_FUSE_I,
    output logic             WD_RESET_O,
    output logic             IRQ_O
);
    ////////////////////////////////////////////////////////////////////////
    // State and helpers.
    ////////////////////////////////////////////////////////////////////////
    wdt_pkg::wdt_state_s r_reg;
    wdt_pkg::wdt_state_s r_next;

    logic        tick;
    logic        expire;
    logic        level2;
    logic        wd_en_eff;
    logic        running;
    logic        ce_open;
    logic        access;
    logic        done;
    logic        hit_ctrl;
    logic        hit_cause;
    logic        wr_ctrl;
    logic        wr_cause;
    logic        cnt_clear;
    logic [7:0]  ctrl_view;
    logic [7:0]  wd;

    // Programmed fuse means level two.
    assign level2 = SAFETY_LEVEL_FUSE_I;
    assign ce_open = (r_reg.ce_state == wdt_pkg::WDT_CE_OPEN);
    assign wd_en_eff = r_reg.wd_en | level2 | r_reg.cause;
    assign running = wd_en_eff | r_reg.irq_en;

    assign access = PSEL_I & PENABLE_I;
    assign done = access & r_reg.pready;
    assign hit_ctrl = (PADDR_I == `WDT_CTRL_ADDR);
    assign hit_cause = (PADDR_I == `WDT_CAUSE_ADDR);
    assign wr_ctrl = done & PWRITE_I & hit_ctrl;
    assign wr_cause = done & PWRITE_I & hit_cause;
    assign wd = PWDATA_I[7:0];

    assign ctrl_view = {r_reg.irq_flag, r_reg.irq_en, r_reg.sel[3],
                        ce_open, wd_en_eff, r_reg.sel[2:0]};

    // The counter is held at zero while stopped and across any reset.
    assign cnt_clear = RESTART_I | ~running | CHIP_RST_I
                       | r_reg.rst_pulse;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator and counter.
    ////////////////////////////////////////////////////////////////////////
    wdt_tick_gen #(
        .DIV (OSC_DIV)
    ) u_tick (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .tick_o   (tick)
    );

    wdt_period_cnt u_cnt (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .tick_i   (tick),
        .clear_i  (cnt_clear),
        .sel_i    (r_reg.sel),
        .expire_o (expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        r_next.rst_pulse = 1'b0;

        // Bus answers one cycle into the access phase.
        r_next.pready = access & ~r_reg.pready;
        if (access & ~r_reg.pready)
        begin
            r_next.pslverr = ~(hit_ctrl | hit_cause);
            r_next.prdata = 32'h0000_0000;
            if (hit_ctrl & ~PWRITE_I)
                r_next.prdata[7:0] = ctrl_view;
            else if (hit_cause & ~PWRITE_I)
                r_next.prdata[`WDT_B_CAUSE] = r_reg.cause;
        end
        else if (~access)
        begin
            r_next.pslverr = 1'b0;
        end

        // Change-enable window counts down in system cycles.
        if (ce_open)
        begin
            if (r_reg.ce_cnt <= 3'h1)
            begin
                r_next.ce_state = wdt_pkg::WDT_CE_CLOSED;
                r_next.ce_cnt = `WDT_RST_CE_CNT;
            end
            else
            begin
                r_next.ce_cnt = r_reg.ce_cnt - 3'h1;
            end
        end

        // Flag clears come first so that a same-cycle time-out wins.
        if (IRQ_TAKEN_I)
            r_next.irq_flag = 1'b0;

        if (wr_ctrl)
        begin
            r_next.irq_en = wd[`WDT_B_IRQ_EN];
            if (wd[`WDT_B_IRQ_FLAG])
                r_next.irq_flag = 1'b0;
            if (wd[`WDT_B_WD_EN])
                r_next.wd_en = 1'b1;
            else if (ce_open & ~level2)
                r_next.wd_en = 1'b0;
            if (~level2 | ce_open)
                r_next.sel = {wd[`WDT_B_SEL_MSB], wd[2:0]};
            if (wd[`WDT_B_CHG_EN] & wd[`WDT_B_WD_EN])
            begin
                r_next.ce_state = wdt_pkg::WDT_CE_OPEN;
                r_next.ce_cnt = 3'(`WDT_CE_CYCLES);
            end
            else if (~wd[`WDT_B_CHG_EN])
            begin
                r_next.ce_state = wdt_pkg::WDT_CE_CLOSED;
                r_next.ce_cnt = `WDT_RST_CE_CNT;
            end
        end

        if (wr_cause & ~wd[`WDT_B_CAUSE])
            r_next.cause = 1'b0;

        // While the cause flag stands the stored enable is held set, so a
        // disable attempt made before the flag is cleared does not stick.
        if (r_reg.cause)
            r_next.wd_en = 1'b1;

        // Action on time-out follows the enable pair.
        if (expire)
        begin
            if (r_reg.irq_en)
            begin
                r_next.irq_flag = 1'b1;
                if (wd_en_eff)
                    r_next.irq_en = 1'b0;
            end
            else if (wd_en_eff)
            begin
                r_next.rst_pulse = 1'b1;
            end
        end

        // A chip reset returns control to its reset values; only power-on or a
        // written zero clears the cause flag, so it survives its own reset.
        if (r_reg.rst_pulse | CHIP_RST_I)
        begin
            r_next.irq_flag = 1'b0;
            r_next.irq_en = 1'b0;
            r_next.sel = `WDT_RST_SEL;
            r_next.wd_en = 1'b0;
            r_next.ce_state = wdt_pkg::WDT_CE_CLOSED;
            r_next.ce_cnt = `WDT_RST_CE_CNT;
            r_next.rst_pulse = 1'b0;
        end
        if (r_reg.rst_pulse)
            r_next.cause = 1'b1;

        // The request rises with the time-out itself, so a time-out that
        // also clears the interrupt enable is still delivered once.
        r_next.irq = r_reg.irq_en & GLOBAL_IRQ_EN_I
                     & (r_reg.irq_flag | expire);
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign PRDATA_O = r_reg.prdata;
    assign PREADY_O = r_reg.pready;
    assign PSLVERR_O = r_reg.pslverr;
    assign WD_RESET_O = r_reg.rst_pulse;
    assign IRQ_O = r_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    sequence s_ce_arm;
        wr_ctrl && wd[`WDT_B_CHG_EN] && wd[`WDT_B_WD_EN];
    endsequence

    a_reset_single: assert property (
        WD_RESET_O |=> !WD_RESET_O)
        else $error("watchdog reset pulse longer than one cycle");

    a_reset_cause: assert property (
        WD_RESET_O |=> r_reg.cause && !r_reg.wd_en && !r_reg.irq_en)
        else $error("cause flag not set after watchdog reset");

    a_ce_window: assert property (
        s_ce_arm ##1 (!wr_ctrl && !CHIP_RST_I && !WD_RESET_O) [*4]
        |=> !ce_open)
        else $error("change-enable not cleared after four cycles");

    a_ce_held: assert property (
        s_ce_arm ##1 (!wr_ctrl && !CHIP_RST_I && !WD_RESET_O) [*3]
        |-> ce_open)
        else $error("change-enable closed too early");

    a_guard_clear: assert property (
        wr_ctrl && !wd[`WDT_B_WD_EN] && !ce_open && r_reg.wd_en
        && !CHIP_RST_I && !WD_RESET_O |=> r_reg.wd_en)
        else $error("enable cleared without change-enable");

    a_level2_on: assert property (
        level2 |-> ctrl_view[`WDT_B_WD_EN] && running)
        else $error("watchdog off in safety level two");

    a_cause_force: assert property (
        r_reg.cause |-> running && !cnt_clear || RESTART_I || CHIP_RST_I
        || WD_RESET_O)
        else $error("watchdog stopped while cause flag set");

    a_irq_gate: assert property (
        IRQ_O |-> $past(GLOBAL_IRQ_EN_I) && $past(r_reg.irq_en)
        && $past(r_reg.irq_flag || expire))
        else $error("interrupt without both enables");

    a_timeout_irq: assert property (
        expire && r_reg.irq_en && !CHIP_RST_I && !WD_RESET_O
        |=> r_reg.irq_flag && !WD_RESET_O)
        else $error("time-out flag not set on interrupt action");

    a_ie_drop: assert property (
        expire && r_reg.irq_en && wd_en_eff && !wr_ctrl
        |=> !r_reg.irq_en)
        else $error("interrupt enable kept after time-out");

    a_reset_act: assert property (
        expire && !r_reg.irq_en && wd_en_eff && !CHIP_RST_I
        |=> WD_RESET_O)
        else $error("no reset on time-out with reset action");

    a_stopped: assert property (
        !running |=> !expire)
        else $error("time-out while stopped");

    // The checks below watch clears and refusals; each leaves out the
    // cycles in which a reset or a time-out takes precedence.
    a_cause_hold: assert property (
        r_reg.cause && !CHIP_RST_I && !WD_RESET_O |=> r_reg.wd_en)
        else $error("enable not held while cause flag set");

    a_flag_w1c: assert property (
        wr_ctrl && wd[`WDT_B_IRQ_FLAG] && !expire |=> !r_reg.irq_flag)
        else $error("time-out flag not cleared by writing one");

    a_vector_clear: assert property (
        IRQ_TAKEN_I && !expire |=> !r_reg.irq_flag)
        else $error("time-out flag not cleared when vector taken");

    a_cause_clear: assert property (
        wr_cause && !wd[`WDT_B_CAUSE] && !WD_RESET_O |=> !r_reg.cause)
        else $error("cause flag not cleared by writing zero");

    a_level2_sel: assert property (
        level2 && wr_ctrl && !ce_open && !CHIP_RST_I && !WD_RESET_O
        |=> $stable(r_reg.sel))
        else $error("period changed without change-enable");

    a_level2_keep: assert property (
        level2 && wr_ctrl && !wd[`WDT_B_WD_EN] && !r_reg.cause
        && !CHIP_RST_I && !WD_RESET_O |=> $stable(r_reg.wd_en))
        else $error("enable write took effect in safety level two");

    a_chip_clear: assert property (
        CHIP_RST_I |=> r_reg.sel == `WDT_RST_SEL && !r_reg.irq_en
        && !r_reg.irq_flag && !r_reg.wd_en)
        else $error("control not returned to reset values");

    a_gie_gate: assert property (
        !GLOBAL_IRQ_EN_I |=> !IRQ_O)
        else $error("interrupt requested with global enable clear");

    c_wd_reset: cover property (WD_RESET_O ##1 r_reg.cause);
    c_irq: cover property (expire ##[1:3] IRQ_O);
    c_disable: cover property (s_ce_arm ##[3:6] (wr_ctrl && !level2
        && !wd[`WDT_B_WD_EN]) ##1 !wd_en_eff);
    c_level2_sel: cover property (level2 && ce_open && wr_ctrl
        && !wd[`WDT_B_CHG_EN]);
    c_cause_hold: cover property (r_reg.cause && wr_ctrl && ce_open
        && !wd[`WDT_B_WD_EN]);

endmodule : wdt_watchdog

// ==== dv/wdt_watchdog_tb.sv ====
// Self-checking bench for the watchdog: APB register access, interrupt and
// reset actions, timed change sequences and both safety levels.
// Assumes the design files are compiled first and OSC_DIV may be shortened.
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_watchdog_tb;

    // A short divider keeps a code 1 time-out near sixteen thousand cycles.
    localparam int          DIV   = 4;
    localparam logic [11:0] CTRL  = `WDT_CTRL_ADDR;
    localparam logic [11:0] CAUSE = `WDT_CAUSE_ADDR;

    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        chip_rst;
    logic        restart;
    logic        irq_taken;
    logic        gie;
    logic        fuse;
    logic        wd_rst;
    logic        irq;
    int          num_errors;
    int          tests_run;

    wdt_watchdog #(.OSC_DIV(DIV)) u_wdt_watchdog (
        .CLK_I               (clk),
        .ARST_N_I            (arst_n),
        .PSEL_I              (psel),
        .PENABLE_I           (penable),
        .PWRITE_I            (pwrite),
        .PADDR_I             (paddr),
        .PWDATA_I            (pwdata),
        .PRDATA_O            (prdata),
        .PREADY_O            (pready),
        .PSLVERR_O           (pslverr),
        .CHIP_RST_I          (chip_rst),
        .RESTART_I           (restart),
        .IRQ_TAKEN_I         (irq_taken),
        .GLOBAL_IRQ_EN_I     (gie),
        .SAFETY_LEVEL_FUSE_I (fuse),
        .WD_RESET_O          (wd_rst),
        .IRQ_O               (irq)
    );

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Called just after a rising edge; a chained call keeps psel high so
    // the next setup follows at once, which the timed sequence relies on.
    // An unchained call lets one edge pass after the release.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input bit chain,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk({31'h0000_0000, pready}, 32'h0000_0001);
        rd  = prdata;
        err = pslverr;
        if (!chain)
        begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input bit chain = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, chain, r, e);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, 1'b0, r, e);
        chk(r, {24'h00_0000, exp});
        chk({31'h0000_0000, e}, 32'h0000_0000);
    endtask : rchk

    task automatic wait_hi(input bit use_rst, output int n);
        n = 0;
        while (((use_rst ? wd_rst : irq) !== 1'b1) && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_hi

    // Allows for the tick phase and the few cycles of register delay.
    task automatic chk_time(input int n, input int ticks);
        int e;
        e = ticks * DIV;
        chk(32'((n >= e - 8 && n <= e + 24) ? e : n), 32'(e));
    endtask : chk_time

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rchk(CTRL, 8'h00);
        rchk(CAUSE, 8'h00);
        apb(1'b0, 12'h090, 32'h0000_0000, 1'b0, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        wr(CTRL, 8'h21);
        rchk(CTRL, 8'h21);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h00);
    endtask : t_regs

    task automatic t_irq;
        int n;
        wr(CTRL, 8'h40);
        wait_hi(1'b0, n);
        chk_time(n, 2048);
        rchk(CTRL, 8'hC0);
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        gie <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        irq_taken <= 1'b1;
        @(posedge clk);
        irq_taken <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rchk(CTRL, 8'h40);
        chip_rst <= 1'b1;
        @(posedge clk);
        chip_rst <= 1'b0;
        @(posedge clk);
        rchk(CTRL, 8'h00);
    endtask : t_irq

    task automatic t_reset;
        int n;
        wr(CTRL, 8'h49);
        repeat (10000) @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        wait_hi(1'b0, n);
        chk_time(n, 4096);
        rchk(CTRL, 8'h89);
        wr(CTRL, 8'h89);
        rchk(CTRL, 8'h09);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        wait_hi(1'b1, n);
        chk_time(n, 4096);
        @(posedge clk);
        chk({31'h0000_0000, wd_rst}, 32'h0000_0000);
        rchk(CAUSE, 8'h08);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h18, 1'b1);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h08);
        wr(CAUSE, 8'h00);
        rchk(CAUSE, 8'h00);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h18);
        repeat (8) @(posedge clk);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h18, 1'b1);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h00);
    endtask : t_reset

    task automatic t_level2;
        fuse   <= 1'b1;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h18, 1'b1);
        wr(CTRL, 8'h00);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h0B);
        rchk(CTRL, 8'h08);
        wr(CTRL, 8'h18, 1'b1);
        wr(CTRL, 8'h03);
        rchk(CTRL, 8'h0B);
    endtask : t_level2

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    initial
    begin
        #(8 * 90000);
        num_errors++;
        stop_test();
    end

    initial
    begin
        clk        = 1'b0;
        arst_n     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        chip_rst   = 1'b0;
        restart    = 1'b0;
        irq_taken  = 1'b0;
        gie        = 1'b1;
        fuse       = 1'b0;
        num_errors = 0;
        tests_run  = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_irq();
        t_reset();
        t_level2();
        stop_test();
    end

endmodule : wdt_watchdog_tb
